// File: core/cpu_alu_dsp_datapath.sv
// Overview of operation
// [RULE_01] Extension bit set when priority exceeds seven
// [RULE_02] Active stack frame: pointers ignore page registers
// [RULE_03] Rounding select one biased, zero convergent
// [RULE_04] Multiply mode one integer, zero fractional
// [RULE_05] Current context field bits 10:8, read-only
// [RULE_06] Manual context field bits 2:0
// [RULE_07] Sixteen-bit ALU, add, subtract, shift, logic
// [RULE_08] Flags C Z N OV DC, borrow on subtract
// [RULE_09] Byte or word operand width per instruction
// [RULE_10] 17x17 multiplier, all listed sign modes
// [RULE_11] Signed/unsigned 32/16 and 16/16 division
// [RULE_12] Quotient to register zero, remainder one
// [RULE_13] Any divisor register, aligned dividend pair
// [RULE_14] One divider cycle per divisor bit
// [RULE_15] Multiplier, 40-bit shifter, adder, two accumulators; the datapath has no 40-bit accumulator shifter
// [RULE_16] Accumulator add, subtract, negate need no data
// [RULE_17] Listed accumulator operations, selective write-back
// [RULE_18] Sign, saturation enables and mode honoured
// [RULE_19] Sign field: 00 signed, 01 unsigned, 10 mixed
// [RULE_20] Saturation mode one 9.31, zero 1.31
// [RULE_21] Reserved context codes never shown, unused bits zero
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "dsp_defines.svh"

module cpu_alu_dsp_datapath (
	input wire logic mclk,
	input wire logic rst_b,
	input wire dsp_pkg::bus_req_t bus,
	output logic [15:0] bus_rdata,
	input wire dsp_pkg::req_t req,
	input wire dsp_pkg::ctx_in_t ctx,
	output dsp_pkg::res_t res,
	output logic busy,
	output logic [39:0] accumulator_a,
	output logic [39:0] accumulator_b,
	output logic [23:0] ptr_addr,
	output logic prio_ext
);

	// ****************************************
	// Arithmetic helpers
	// ****************************************

	// Widen a 16-bit operand to 17 bits, signed or not
	function automatic logic [16:0] ext17(input logic [15:0] v,
		input logic s);
		ext17 = {s & v[15], v};
	endfunction

	// Shared 17x17 signed multiplier
	function automatic logic [33:0] mul17(input logic [16:0] a,
		input logic [16:0] b);
		mul17 = 34'($signed(a) * $signed(b));
	endfunction

	// Clamp a 41-bit sum into the accumulator
	function automatic logic [39:0] sat40(input logic [40:0] v,
		input logic en, input logic sup);
		logic ov41;
		logic ov32;
		ov41 = v[40] ^ v[39];
		ov32 = ~((&v[39:31]) | ~(|v[39:31]));
		sat40 = v[39:0];
		if (en && ov41) begin
			sat40 = sup ? {v[40], {39{~v[40]}}}
				: {{9{v[40]}}, {31{~v[40]}}};
		end else if (en && !sup && ov32) begin
			sat40 = {{9{v[40]}}, {31{~v[40]}}};
		end
	endfunction

	// Round an accumulator to a 16-bit word for data writes
	function automatic logic [15:0] rnd16(input logic [39:0] a,
		input logic biased, input logic write_saturate_enable);
		logic inc;
		logic [23:0] r;
		inc = biased ? a[15] : (a[15] & ((|a[14:0]) | a[16]));
		r = a[39:16] + {23'h000000, inc};
		rnd16 = r[15:0];
		if (write_saturate_enable && ((&r[23:15]) == 1'b0) && ((|r[23:15]) == 1'b1))
			rnd16 = r[23] ? 16'h8000 : 16'h7FFF;
	endfunction

	// ****************************************
	// State
	// ****************************************

	dsp_pkg::st_t st_q;
	dsp_pkg::st_t st_d;

	// Working signals of the next-state process
	logic [15:0] bx;
	logic [15:0] bb;
	logic [16:0] sum;
	logic [15:0] rv;
	logic [3:0] sh;
	logic carry;
	logic dcar;
	logic am;
	logic bm;
	logic msb;
	logic sx;
	logic sy;
	logic [16:0] ma;
	logic [16:0] mb;
	logic [16:0] dif;
	logic [33:0] prod;
	logic [39:0] p40;
	logic [39:0] cur;
	logic [39:0] oth;
	logic [40:0] s41;
	logic [39:0] nacc;
	logic sat_en;
	logic [31:0] dvd;
	logic dneg;
	logic [17:0] trial;
	logic ge;
	logic [16:0] npart;
	logic [15:0] nlo;
	logic [15:0] aw;

	// ****************************************
	// Next state
	// ****************************************

	always_comb begin
		st_d = st_q;
		bx = 16'h0000;
		bb = 16'h0000;
		sum = 17'h00000;
		rv = 16'h0000;
		sh = req.y[3:0];
		carry = 1'b0;
		dcar = 1'b0;
		am = 1'b0;
		bm = 1'b0;
		msb = 1'b0;
		sx = 1'b0;
		sy = 1'b0;
		ma = 17'h00000;
		mb = 17'h00000;
		dif = 17'h00000;
		prod = 34'h000000000;
		p40 = 40'h0000000000;
		cur = req.acc_b ? st_q.accumulator_b : st_q.accumulator_a;
		oth = req.acc_b ? st_q.accumulator_a : st_q.accumulator_b;
		s41 = {cur[39], cur};
		nacc = cur;
		sat_en = req.acc_b ? st_q.ctl.acc_b_saturate_enable : st_q.ctl.acc_a_saturate_enable;
		dvd = 32'h00000000;
		dneg = 1'b0;
		trial = 18'h00000;
		ge = 1'b0;
		npart = 17'h00000;
		nlo = 16'h0000;
		aw = req.byte_mode ? {8'h00, req.x[7:0]} : req.x;
		st_d.res.valid = 1'b0;
		st_d.res.div_done = 1'b0;
		st_d.res.wb_valid = 1'b0;
		st_d.res.upd = '0;
		st_d.rdata = 16'h0000;

		// [RULE_01] Priority extension status
		st_d.iplx = ctx.prio_level > `PRIO_BASE_MAX;
		// [RULE_05] [RULE_21] Current context, reserved codes dropped
		if (ctx.cur_ctx <= `CTX_MAX)
			st_d.cctx = ctx.cur_ctx;
		// [RULE_06] Manual context from the sequencer
		if (ctx.man_sel && ctx.man_ctx <= `CTX_MAX)
			st_d.mctx = ctx.man_ctx;
		if (ctx.sfa_set)
			st_d.stack_frame_active = 1'b1;
		else if (ctx.sfa_clr)
			st_d.stack_frame_active = 1'b0;

		// [RULE_02] Frame and stack pointer address space
		if (st_q.stack_frame_active || !ctx.ptr_ea[15])
			st_d.ptr_addr = {8'h00, ctx.ptr_ea};
		else
			st_d.ptr_addr = {1'b0, ctx.ptr_wr ? ctx.wr_page : ctx.rd_page,
				ctx.ptr_ea[14:0]};

		// Register port writes
		if (bus.wr) begin
			unique case (bus.addr)
				`REG_CORE_CTRL: begin
					st_d.ctl.us = bus.wdata[`CC_US_HI:`CC_US_LO];
					st_d.ctl.acc_a_saturate_enable = bus.wdata[`CC_ACC_A_SATURATE_ENABLE];
					st_d.ctl.acc_b_saturate_enable = bus.wdata[`CC_ACC_B_SATURATE_ENABLE];
					st_d.ctl.write_saturate_enable = bus.wdata[`CC_WRITE_SATURATE_ENABLE];
					st_d.ctl.saturation_mode_select = bus.wdata[`CC_SATURATION_MODE_SELECT];
					st_d.ctl.rnd = bus.wdata[`CC_RND];
					st_d.ctl.imode = bus.wdata[`CC_IF];
				end
				`REG_CTX_STAT: begin
					// [RULE_21] Reserved manual code ignored
					if (bus.wdata[1:0] != 2'h3)
						st_d.mctx = {1'b0, bus.wdata[1:0]};
				end
				`REG_DSP_STAT: begin
					st_d.sa = st_q.sa & bus.wdata[`ST_SA];
					st_d.sb = st_q.sb & bus.wdata[`ST_SB];
				end
				default: ;
			endcase
		end

		// Register port reads, answered next cycle
		if (bus.rd) begin
			unique case (bus.addr)
				`REG_CORE_CTRL: begin
					st_d.rdata[`CC_US_HI:`CC_US_LO] = st_q.ctl.us;
					st_d.rdata[`CC_ACC_A_SATURATE_ENABLE] = st_q.ctl.acc_a_saturate_enable;
					st_d.rdata[`CC_ACC_B_SATURATE_ENABLE] = st_q.ctl.acc_b_saturate_enable;
					st_d.rdata[`CC_WRITE_SATURATE_ENABLE] = st_q.ctl.write_saturate_enable;
					st_d.rdata[`CC_SATURATION_MODE_SELECT] = st_q.ctl.saturation_mode_select;
					st_d.rdata[`CC_IPLX] = st_q.iplx;
					st_d.rdata[`CC_SFA] = st_q.stack_frame_active;
					st_d.rdata[`CC_RND] = st_q.ctl.rnd;
					st_d.rdata[`CC_IF] = st_q.ctl.imode;
				end
				`REG_CTX_STAT: begin
					// [RULE_21] Unused bits read zero
					st_d.rdata[`CTX_CUR_HI:`CTX_CUR_LO] = st_q.cctx;
					st_d.rdata[`CTX_MAN_HI:`CTX_MAN_LO] = st_q.mctx;
				end
				`REG_DSP_STAT: begin
					st_d.rdata[`ST_OA] = st_q.oa;
					st_d.rdata[`ST_OB] = st_q.ob;
					st_d.rdata[`ST_SA] = st_q.sa;
					st_d.rdata[`ST_SB] = st_q.sb;
				end
				default: ;
			endcase
		end

		// DSP multiplier operands
		// [RULE_19] Sign field decode, reserved code as signed
		sx = st_q.ctl.us != 2'h1;
		sy = st_q.ctl.us == 2'h0 || st_q.ctl.us == 2'h3;
		// [RULE_15] Shared multiplier, squared difference path
		if (req.op == dsp_pkg::OP_ED || req.op == dsp_pkg::OP_SQUARED_DIFFERENCE_ACCUM_OP) begin
			dif = 17'({req.x[15], req.x} - {req.y[15], req.y});
			prod = mul17(dif, dif);
		end else begin
			prod = mul17(ext17(req.x, sx), ext17(req.y, sy));
		end
		// [RULE_04] Integer or fractional product
		if (st_q.ctl.imode)
			p40 = {{6{prod[33]}}, prod};
		else
			p40 = {{6{prod[32]}}, prod[32:0], 1'b0};

		if (req.valid && !st_q.dbusy) begin
			unique case (req.op)
				// [RULE_07] [RULE_09] Add and subtract, byte or word
				dsp_pkg::OP_ADD, dsp_pkg::OP_SUB: begin
					bx = req.byte_mode ? {8'h00, req.y[7:0]} : req.y;
					bb = (req.op == dsp_pkg::OP_SUB) ? ~bx : bx;
					if (req.byte_mode)
						bb[15:8] = 8'h00;
					sum = {1'b0, aw} + {1'b0, bb}
						+ {16'h0000, req.op == dsp_pkg::OP_SUB};
					// [RULE_08] Carry is not-borrow on subtract
					carry = req.byte_mode ? sum[8] : sum[16];
					dcar = req.byte_mode
						? (5'({1'b0, aw[3:0]} + {1'b0, bb[3:0]})
						+ {4'h0, req.op == dsp_pkg::OP_SUB}) > 5'h0F
						: (9'({1'b0, aw[7:0]} + {1'b0, bb[7:0]})
						+ {8'h00, req.op == dsp_pkg::OP_SUB}) > 9'h0FF;
					am = req.byte_mode ? aw[7] : aw[15];
					bm = req.byte_mode ? bb[7] : bb[15];
					rv = req.byte_mode ? {8'h00, sum[7:0]} : sum[15:0];
					msb = req.byte_mode ? rv[7] : rv[15];
					st_d.res.fl.c = carry;
					st_d.res.fl.dc = dcar;
					st_d.res.fl.ov = (am == bm) && (msb != am);
					st_d.res.upd = '1;
				end
				// [RULE_07] Logic operations and shifts
				dsp_pkg::OP_AND: rv = aw & req.y;
				dsp_pkg::OP_IOR: rv = aw | req.y;
				dsp_pkg::OP_XOR: rv = aw ^ req.y;
				dsp_pkg::OP_SHL: rv = aw << sh;
				dsp_pkg::OP_LSR: rv = aw >> sh;
				dsp_pkg::OP_ASR: begin
					if (req.byte_mode)
						rv = {8'h00, 8'($signed(aw[7:0]) >>> sh)};
					else
						rv = 16'($signed(aw) >>> sh);
				end
				// [RULE_10] Integer multiply modes
				dsp_pkg::OP_MUL: begin
					unique case (req.mmode)
						dsp_pkg::MUL_SS: begin
							ma = ext17(req.x, 1'b1);
							mb = ext17(req.y, 1'b1);
						end
						dsp_pkg::MUL_UU: begin
							ma = ext17(req.x, 1'b0);
							mb = ext17(req.y, 1'b0);
						end
						dsp_pkg::MUL_SU: begin
							ma = ext17(req.x, 1'b1);
							mb = ext17(req.y, 1'b0);
						end
						dsp_pkg::MUL_US: begin
							ma = ext17(req.x, 1'b0);
							mb = ext17(req.y, 1'b1);
						end
						dsp_pkg::MUL_SLIT: begin
							ma = ext17(req.x, 1'b1);
							mb = {12'h000, req.y[4:0]};
						end
						dsp_pkg::MUL_ULIT: begin
							ma = ext17(req.x, 1'b0);
							mb = {12'h000, req.y[4:0]};
						end
						dsp_pkg::MUL_UB8: begin
							ma = {9'h000, req.x[7:0]};
							mb = {9'h000, req.y[7:0]};
						end
						default: ;
					endcase
					prod = mul17(ma, mb);
					st_d.res.valid = 1'b1;
					st_d.res.lo = prod[15:0];
					st_d.res.hi = prod[31:16];
				end
				// [RULE_11] [RULE_13] Divide start, magnitudes
				dsp_pkg::OP_DIV: begin
					dvd = req.div_long ? {req.x_hi, req.x}
						: {{16{req.div_signed & req.x[15]}}, req.x};
					dneg = req.div_signed & dvd[31];
					if (dneg)
						dvd = 32'(-dvd);
					st_d.dpart = {1'b0, dvd[31:16]};
					st_d.dlo = dvd[15:0];
					st_d.dvsr = (req.div_signed & req.y[15])
						? 16'(-req.y) : req.y;
					st_d.qneg = dneg ^ (req.div_signed & req.y[15]);
					st_d.rneg = dneg;
					st_d.dcnt = `DIV_STEPS;
					st_d.dbusy = 1'b1;
				end
				// [RULE_17] Accumulator operation table
				dsp_pkg::OP_CLR: s41 = 41'h00000000000;
				dsp_pkg::OP_ED, dsp_pkg::OP_MPY: s41 = {p40[39], p40};
				dsp_pkg::OP_SQUARED_DIFFERENCE_ACCUM_OP, dsp_pkg::OP_MAC:
					s41 = {cur[39], cur} + {p40[39], p40};
				dsp_pkg::OP_PREFETCH_MOVE_OP: s41 = {cur[39], cur};
				dsp_pkg::OP_MPYN: s41 = 41'(-{p40[39], p40});
				dsp_pkg::OP_MSC:
					s41 = {cur[39], cur} - {p40[39], p40};
				// [RULE_16] Accumulator to accumulator operations
				dsp_pkg::OP_AADD: s41 = {cur[39], cur} + {oth[39], oth};
				dsp_pkg::OP_ASUB: s41 = {cur[39], cur} - {oth[39], oth};
				dsp_pkg::OP_ANEG: s41 = 41'(-{cur[39], cur});
				default: ;
			endcase

			// [RULE_08] Zero and negative on ALU results
			if (req.op inside {dsp_pkg::OP_ADD, dsp_pkg::OP_SUB,
				dsp_pkg::OP_AND, dsp_pkg::OP_IOR, dsp_pkg::OP_XOR,
				dsp_pkg::OP_SHL, dsp_pkg::OP_LSR, dsp_pkg::OP_ASR}) begin
				if (req.byte_mode)
					rv[15:8] = 8'h00;
				st_d.res.valid = 1'b1;
				st_d.res.lo = rv;
				st_d.res.hi = 16'h0000;
				st_d.res.fl.z = rv == 16'h0000;
				st_d.res.fl.n = req.byte_mode ? rv[7] : rv[15];
				st_d.res.upd.z = 1'b1;
				st_d.res.upd.n = 1'b1;
			end

			if (req.op >= dsp_pkg::OP_CLR) begin
				// [RULE_18] [RULE_20] Saturation per accumulator
				nacc = sat40(s41, sat_en, st_q.ctl.saturation_mode_select);
				if (req.acc_b) begin
					st_d.accumulator_b = nacc;
					st_d.ob = (s41[40] ^ s41[39]) |
						~((&nacc[39:31]) | ~(|nacc[39:31]));
					st_d.sb = st_d.sb | (nacc != s41[39:0]);
				end else begin
					st_d.accumulator_a = nacc;
					st_d.oa = (s41[40] ^ s41[39]) |
						~((&nacc[39:31]) | ~(|nacc[39:31]));
					st_d.sa = st_d.sa | (nacc != s41[39:0]);
				end
				// [RULE_17] [RULE_03] Rounded write-back of other acc
				if (req.wb_en && req.op inside {dsp_pkg::OP_CLR,
					dsp_pkg::OP_MAC, dsp_pkg::OP_PREFETCH_MOVE_OP,
					dsp_pkg::OP_MSC}) begin
					st_d.res.wb_valid = 1'b1;
					st_d.res.wb_data = rnd16(oth, st_q.ctl.rnd,
						st_q.ctl.write_saturate_enable);
				end
			end
		end

		// [RULE_14] Restoring divide, one step per divisor bit
		if (st_q.dbusy) begin
			trial = {st_q.dpart, st_q.dlo[15]};
			ge = trial >= {2'b00, st_q.dvsr};
			npart = ge ? 17'(trial - {2'b00, st_q.dvsr}) : trial[16:0];
			nlo = {st_q.dlo[14:0], ge};
			st_d.dpart = npart;
			st_d.dlo = nlo;
			st_d.dcnt = st_q.dcnt - 5'h01;
			if (st_q.dcnt == 5'h01) begin
				// [RULE_12] Quotient low word, remainder high word
				st_d.dbusy = 1'b0;
				st_d.res.valid = 1'b1;
				st_d.res.div_done = 1'b1;
				st_d.res.lo = st_q.qneg ? 16'(-nlo) : nlo;
				st_d.res.hi = st_q.rneg ? 16'(-npart[15:0])
					: npart[15:0];
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.ctl.write_saturate_enable <= 1'(`CORE_CTRL_RST >> `CC_WRITE_SATURATE_ENABLE);
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign bus_rdata = st_q.rdata;
	assign res = st_q.res;
	assign busy = st_q.dbusy;
	assign accumulator_a = st_q.accumulator_a;
	assign accumulator_b = st_q.accumulator_b;
	assign ptr_addr = st_q.ptr_addr;
	assign prio_ext = st_q.iplx;

endmodule // cpu_alu_dsp_datapath

// File: core/dsp_defines.svh
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH

// Register offsets on the register port
`define REG_CORE_CTRL 2'h0
`define REG_CTX_STAT 2'h1
`define REG_DSP_STAT 2'h2

// Core control field positions
`define CC_US_HI 13
`define CC_US_LO 12
`define CC_ACC_A_SATURATE_ENABLE 7
`define CC_ACC_B_SATURATE_ENABLE 6
`define CC_WRITE_SATURATE_ENABLE 5
`define CC_SATURATION_MODE_SELECT 4
`define CC_IPLX 3
`define CC_SFA 2
`define CC_RND 1
`define CC_IF 0
`define CORE_CTRL_RST 16'h0020

// Context status field positions
`define CTX_CUR_HI 10
`define CTX_CUR_LO 8
`define CTX_MAN_HI 2
`define CTX_MAN_LO 0
`define CTX_MAX 3'h2

// Accumulator status field positions
`define ST_OA 3
`define ST_OB 2
`define ST_SA 1
`define ST_SB 0

// Priority level above which the extension bit is set
`define PRIO_BASE_MAX 4'h7

// Divider iterations, one per divisor bit
`define DIV_STEPS 5'h10

`endif

// File: core/dsp_pkg.sv
package dsp_pkg;

	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHL, OP_LSR,
		OP_ASR, OP_MUL, OP_DIV, OP_CLR, OP_ED, OP_SQUARED_DIFFERENCE_ACCUM_OP, OP_MAC,
		OP_PREFETCH_MOVE_OP, OP_MPY, OP_MPYN, OP_MSC, OP_AADD, OP_ASUB, OP_ANEG
	} op_t;

	typedef enum logic [2:0] {
		MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_UB8
	} mul_mode_t;

	typedef struct packed {
		logic valid;
		op_t op;
		logic byte_mode;
		mul_mode_t mmode;
		logic div_signed;
		logic div_long;
		logic acc_b;
		logic wb_en;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] x_hi;
	} req_t;

	typedef struct packed {
		logic [3:0] prio_level;
		logic [2:0] cur_ctx;
		logic man_sel;
		logic [2:0] man_ctx;
		logic sfa_set;
		logic sfa_clr;
		logic [15:0] ptr_ea;
		logic [7:0] rd_page;
		logic [7:0] wr_page;
		logic ptr_wr;
	} ctx_in_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] addr;
		logic [15:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic c;
		logic z;
		logic n;
		logic ov;
		logic dc;
	} flags_t;

	typedef struct packed {
		logic [1:0] us;
		logic acc_a_saturate_enable;
		logic acc_b_saturate_enable;
		logic write_saturate_enable;
		logic saturation_mode_select;
		logic rnd;
		logic imode;
	} ctrl_t;

	typedef struct packed {
		logic valid;
		logic [15:0] lo;
		logic [15:0] hi;
		flags_t fl;
		flags_t upd;
		logic div_done;
		logic wb_valid;
		logic [15:0] wb_data;
	} res_t;

	typedef struct packed {
		ctrl_t ctl;
		logic stack_frame_active;
		logic iplx;
		logic [2:0] cctx;
		logic [2:0] mctx;
		logic [39:0] accumulator_a;
		logic [39:0] accumulator_b;
		logic oa;
		logic ob;
		logic sa;
		logic sb;
		logic dbusy;
		logic [4:0] dcnt;
		logic [16:0] dpart;
		logic [15:0] dlo;
		logic [15:0] dvsr;
		logic qneg;
		logic rneg;
		res_t res;
		logic [15:0] rdata;
		logic [23:0] ptr_addr;
	} st_t;

endpackage

// File: dv/alu_dsp_monitor.sv
`timescale 1ns/1ns
module alu_dsp_monitor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire dsp_pkg::bus_req_t bus,
	input wire logic [15:0] bus_rdata,
	input wire dsp_pkg::req_t req,
	input wire dsp_pkg::ctx_in_t ctx,
	input wire dsp_pkg::res_t res,
	input wire logic busy,
	input wire logic [39:0] accumulator_a,
	input wire logic [39:0] accumulator_b,
	input wire logic [23:0] ptr_addr,
	input wire logic prio_ext
);
	logic take;
	// ****
	// Checks
	// ****
	// Request accepted at this edge
	assign take = req.valid && !busy;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_PRIO_SET: assert property (ctx.prio_level > 4'h7 |=> prio_ext)
		else $error("priority bit low");
	AST_PRIO_CLR: assert property (ctx.prio_level <= 4'h7 |=> !prio_ext)
		else $error("priority bit high");
	AST_PTR_BASE: assert property (!ctx.ptr_ea[15] |=>
		ptr_addr == {8'h00, $past(ctx.ptr_ea)}) else $error("pointer address");
	AST_CTX_READ: assert property (bus.rd && bus.addr == 2'h1 |=>
		bus_rdata[15:11] == 5'h00 && bus_rdata[7:3] == 5'h00 &&
		bus_rdata[10:8] <= 3'h2 && bus_rdata[2:0] <= 3'h2)
		else $error("context status bits");
	AST_ADD_WORD: assert property (take && req.op == dsp_pkg::OP_ADD &&
		!req.byte_mode |=> res.valid && res.fl.n == res.lo[15] &&
		res.lo == $past(req.x) + $past(req.y)) else $error("add result");
	AST_SUB_BORROW: assert property (take && req.op == dsp_pkg::OP_SUB &&
		!req.byte_mode |=> res.fl.c == ($past(req.x) >= $past(req.y)))
		else $error("borrow flag");
	AST_BYTE_UPPER: assert property (take && req.byte_mode &&
		req.op inside {dsp_pkg::OP_ADD, dsp_pkg::OP_SUB} |=>
		res.lo[15:8] == 8'h00) else $error("byte upper half");
	AST_DIV_TIME: assert property (take && req.op == dsp_pkg::OP_DIV |=>
		busy[*8] ##1 busy[*8] ##1 (!busy && res.div_done && res.valid))
		else $error("divide timing");
	AST_DIV_QUIET: assert property (busy |-> !res.valid)
		else $error("result during divide");
	AST_CLR: assert property (take && req.op == dsp_pkg::OP_CLR &&
		!req.acc_b |=> accumulator_a == 40'h0000000000 && $stable(accumulator_b))
		else $error("clear accumulator");
	AST_ACC_NEG: assert property (take && req.op == dsp_pkg::OP_ANEG &&
		!req.acc_b |=> accumulator_a == -$past(accumulator_a)) else $error("negate");
	AST_NO_WB: assert property (take && req.op inside {dsp_pkg::OP_MPY,
		dsp_pkg::OP_MPYN, dsp_pkg::OP_ED, dsp_pkg::OP_SQUARED_DIFFERENCE_ACCUM_OP} |=> !res.wb_valid)
		else $error("write-back on plain op");
	COV_DIV: cover property (take && req.op == dsp_pkg::OP_DIV);
	COV_WB: cover property (res.wb_valid);
	COV_MAC: cover property (take && req.op == dsp_pkg::OP_MAC);
endmodule // alu_dsp_monitor

bind cpu_alu_dsp_datapath alu_dsp_monitor i_alu_dsp_monitor (.mclk(mclk),
	.rst_b(rst_b), .bus(bus), .bus_rdata(bus_rdata), .req(req), .ctx(ctx),
	.res(res), .busy(busy), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .ptr_addr(ptr_addr),
	.prio_ext(prio_ext));

// File: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic mclk;
	logic rst_b;
	dsp_pkg::bus_req_t bus;
	logic [15:0] bus_rdata;
	dsp_pkg::req_t req;
	dsp_pkg::req_t nx;
	dsp_pkg::ctx_in_t ctx;
	dsp_pkg::res_t res;
	logic busy;
	logic [39:0] accumulator_a;
	logic [39:0] accumulator_b;
	logic [23:0] ptr_addr;
	logic prio_ext;
	logic [15:0] quotient_reg;
	logic [15:0] remainder_reg;
	logic [15:0] rdv;
	int miscompares;
	int total_checks;
	int n;
	logic [31:0] mx [7];

	cpu_alu_dsp_datapath i_cpu_alu_dsp_datapath (.mclk(mclk), .rst_b(rst_b),
		.bus(bus), .bus_rdata(bus_rdata), .req(req), .ctx(ctx), .res(res),
		.busy(busy), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .ptr_addr(ptr_addr),
		.prio_ext(prio_ext));
	work_reg_model i_work_reg_model (.mclk(mclk), .rst_b(rst_b), .res(res),
		.quotient_reg(quotient_reg), .remainder_reg(remainder_reg));

	// ****
	// Clock and access tasks
	// ****
	// Clock of 20 ns period
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	task automatic rc(input logic [1:0] a, input logic [15:0] e);
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 rdv = bus_rdata;
		chk(rdv, e);
	endtask

	task automatic issue(input dsp_pkg::op_t o, input logic [15:0] x,
		input logic [15:0] y);
		@(posedge mclk);
		nx.valid = 1'b1;
		nx.op = o;
		nx.x = x;
		nx.y = y;
		req <= nx;
		@(posedge mclk);
		req.valid <= 1'b0;
		#1;
	endtask

	task automatic alu(input dsp_pkg::op_t o, input logic [15:0] x,
		input logic [15:0] y, input logic [15:0] e);
		issue(o, x, y);
		chk(res.lo, e);
	endtask

	task automatic dsp(input dsp_pkg::op_t o, input logic [15:0] x,
		input logic [15:0] y, input logic [39:0] e);
		issue(o, x, y);
		chk(accumulator_a, e);
	endtask

	// Divide with a dropped request while busy
	task automatic dv(input logic [15:0] x, input logic [15:0] y,
		input logic [15:0] q, input logic [15:0] r);
		issue(dsp_pkg::OP_DIV, x, y);
		issue(dsp_pkg::OP_ADD, 16'h0001, 16'h0001);
		chk(res.valid, 1'b0);
		n = 3;
		while (res.div_done !== 1'b1 && n < 40) begin
			@(posedge mclk);
			#1 n++;
		end
		chk(n, 17);
		@(posedge mclk);
		#1 chk(quotient_reg, q);
		chk(remainder_reg, r);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		repeat (4000) @(posedge mclk);
		miscompares++;
		summarize();
	end

	// ****
	// Test sequence
	// ****
	initial begin
		bus = '0;
		req = '0;
		nx = '0;
		ctx = '0;
		rst_b = 1'b0;
		mx = '{32'hFFFFFFFE, 32'h0001FFFE, 32'hFFFFFFFE, 32'h0001FFFE,
			32'hFFFFFFFE, 32'h0001FFFE, 32'h000001FE};
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		rc(2'h0, 16'h0020);
		rc(2'h1, 16'h0000);
		wr(2'h0, 16'hFFFF);
		rc(2'h0, 16'h30F3);
		wr(2'h3, 16'hFFFF);
		rc(2'h3, 16'h0000);
		@(posedge mclk);
		ctx.prio_level <= 4'h8;
		rc(2'h0, 16'h30FB);
		chk(prio_ext, 1'b1);
		@(posedge mclk);
		ctx.prio_level <= 4'h7;
		rc(2'h0, 16'h30F3);
		$display("test control register done");
		@(posedge mclk);
		ctx.cur_ctx <= 3'h2;
		ctx.man_sel <= 1'b1;
		ctx.man_ctx <= 3'h1;
		@(posedge mclk);
		ctx.man_sel <= 1'b0;
		ctx.cur_ctx <= 3'h3;
		rc(2'h1, 16'h0201);
		wr(2'h1, 16'h0003);
		rc(2'h1, 16'h0201);
		wr(2'h1, 16'hFFFA);
		rc(2'h1, 16'h0202);
		@(posedge mclk);
		ctx.sfa_set <= 1'b1;
		ctx.ptr_ea <= 16'h9000;
		ctx.rd_page <= 8'h05;
		ctx.wr_page <= 8'h0A;
		@(posedge mclk);
		ctx.sfa_set <= 1'b0;
		rc(2'h0, 16'h30F7);
		chk(ptr_addr, 24'h009000);
		@(posedge mclk);
		ctx.sfa_clr <= 1'b1;
		@(posedge mclk);
		ctx.sfa_clr <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk(ptr_addr, 24'h029000);
		@(posedge mclk);
		ctx.ptr_wr <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk(ptr_addr, 24'h051000);
		$display("test context done");
		alu(dsp_pkg::OP_ADD, 16'h7FFF, 16'h0001, 16'h8000);
		chk(res.fl, 5'b00111);
		chk(res.upd, 5'b11111);
		alu(dsp_pkg::OP_SUB, 16'h0001, 16'h0002, 16'hFFFF);
		chk(res.fl, 5'b00100);
		alu(dsp_pkg::OP_SUB, 16'h0105, 16'h0003, 16'h0102);
		chk(res.fl, 5'b10001);
		alu(dsp_pkg::OP_AND, 16'hF0F0, 16'hFF00, 16'hF000);
		chk(res.upd, 5'b01100);
		alu(dsp_pkg::OP_IOR, 16'hF0F0, 16'hFF00, 16'hFFF0);
		alu(dsp_pkg::OP_XOR, 16'hF0F0, 16'hFF00, 16'h0FF0);
		alu(dsp_pkg::OP_SHL, 16'h8001, 16'h0001, 16'h0002);
		alu(dsp_pkg::OP_LSR, 16'h8000, 16'h0004, 16'h0800);
		alu(dsp_pkg::OP_ASR, 16'h8000, 16'h0004, 16'hF800);
		nx.byte_mode = 1'b1;
		alu(dsp_pkg::OP_ADD, 16'h00FF, 16'h0001, 16'h0000);
		chk(res.fl, 5'b11001);
		nx.byte_mode = 1'b0;
		for (int m = 0; m < 7; m++) begin
			nx.mmode = dsp_pkg::mul_mode_t'(m);
			issue(dsp_pkg::OP_MUL, 16'hFFFF, 16'h0002);
			chk({res.hi, res.lo}, mx[m]);
		end
		$display("test alu done");
		dv(16'h0064, 16'h0007, 16'h000E, 16'h0002);
		nx.div_signed = 1'b1;
		dv(16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
		nx.div_long = 1'b1;
		nx.x_hi = 16'hFFFF;
		dv(16'hFF9C, 16'h0007, 16'hFFF2, 16'hFFFE);
		nx.div_signed = 1'b0;
		nx.x_hi = 16'h0001;
		dv(16'h0000, 16'h0002, 16'h8000, 16'h0000);
		nx.div_long = 1'b0;
		$display("test divide done");
		wr(2'h0, 16'h0001);
		dsp(dsp_pkg::OP_CLR, 16'h0000, 16'h0000, 40'h0);
		dsp(dsp_pkg::OP_MPY, 16'h0003, 16'h0004, 40'hC);
		dsp(dsp_pkg::OP_MAC, 16'h0002, 16'h0005, 40'h16);
		dsp(dsp_pkg::OP_MSC, 16'h0001, 16'h0002, 40'h14);
		dsp(dsp_pkg::OP_MPYN, 16'h0002, 16'h0003, 40'hFFFFFFFFFA);
		dsp(dsp_pkg::OP_ED, 16'h0005, 16'h0002, 40'h9);
		dsp(dsp_pkg::OP_SQUARED_DIFFERENCE_ACCUM_OP, 16'h0005, 16'h0002, 40'h12);
		dsp(dsp_pkg::OP_PREFETCH_MOVE_OP, 16'h0000, 16'h0000, 40'h12);
		dsp(dsp_pkg::OP_ANEG, 16'h0000, 16'h0000, 40'hFFFFFFFFEE);
		nx.acc_b = 1'b1;
		issue(dsp_pkg::OP_MPY, 16'h0001, 16'h0007);
		chk(accumulator_b, 40'h7);
		nx.acc_b = 1'b0;
		dsp(dsp_pkg::OP_AADD, 16'h0000, 16'h0000, 40'hFFFFFFFFF5);
		dsp(dsp_pkg::OP_ASUB, 16'h0000, 16'h0000, 40'hFFFFFFFFEE);
		dsp(dsp_pkg::OP_MPY, 16'hFFFF, 16'hFFFF, 40'h1);
		wr(2'h0, 16'h1001);
		dsp(dsp_pkg::OP_MPY, 16'hFFFF, 16'hFFFF, 40'hFFFE0001);
		wr(2'h0, 16'h2001);
		dsp(dsp_pkg::OP_MPY, 16'hFFFF, 16'hFFFF, 40'hFFFFFF0001);
		wr(2'h0, 16'h0000);
		dsp(dsp_pkg::OP_MPY, 16'h0003, 16'h0004, 40'h18);
		wr(2'h0, 16'h0080);
		dsp(dsp_pkg::OP_MPY, 16'h7FFF, 16'h7FFF, 40'h7FFE0002);
		dsp(dsp_pkg::OP_MAC, 16'h7FFF, 16'h7FFF, 40'h7FFFFFFF);
		rc(2'h2, 16'h0002);
		chk(rdv[1], 1'b1);
		wr(2'h2, 16'h0000);
		rc(2'h2, 16'h0000);
		chk(rdv[1:0], 2'b00);
		wr(2'h0, 16'h0090);
		dsp(dsp_pkg::OP_MPY, 16'h7FFF, 16'h7FFF, 40'h7FFE0002);
		dsp(dsp_pkg::OP_MAC, 16'h7FFF, 16'h7FFF, 40'hFFFC0004);
		wr(2'h0, 16'h1001);
		nx.acc_b = 1'b1;
		issue(dsp_pkg::OP_MPY, 16'h0001, 16'h8000);
		nx.acc_b = 1'b0;
		nx.wb_en = 1'b1;
		issue(dsp_pkg::OP_PREFETCH_MOVE_OP, 16'h0000, 16'h0000);
		chk(res.wb_valid, 1'b1);
		chk(res.wb_data, 16'h0000);
		wr(2'h0, 16'h1003);
		issue(dsp_pkg::OP_PREFETCH_MOVE_OP, 16'h0000, 16'h0000);
		chk(res.wb_data, 16'h0001);
		nx.wb_en = 1'b0;
		$display("test dsp engine done");
		summarize();
	end
endmodule // testbench

// File: dv/work_reg_model.sv
`timescale 1ns/1ns
module work_reg_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire dsp_pkg::res_t res,
	output logic [15:0] quotient_reg,
	output logic [15:0] remainder_reg
);
	// ****
	// Divide result capture
	// ****
	// quotient and remainder
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			quotient_reg <= 16'h0000;
			remainder_reg <= 16'h0000;
		end else if (res.div_done) begin
			quotient_reg <= res.lo;
			remainder_reg <= res.hi;
		end
	end
endmodule // work_reg_model
